/* File: logic/asrx_core.sv */
// apb serial receiver/transmitter with standby wakeup, 16x oversampling and break handling
`timescale 1ns/1ps
`default_nettype none
module asrx_core (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      rx_serial_in,
  output logic                           tx_serial_out,
  output logic                           irq
);
  import asrx_pkg::*;

  typedef struct packed {
    asrx_rx_state_type rx_state;
    logic [4:0]        rt_cnt;
    logic [3:0]        bit_idx;
    logic [2:0]        smp;
    logic [1:0]        ver_low;
    logic              noise_acc;
    logic [8:0]        rx_shift;
    logic              hi_seen;
    logic              fe_hold;
    logic [7:0]        idle_cnt;
    logic              char_seen;
    logic [7:0]        rx_data;
    asrx_status_type   flags;
    asrx_status_type   armed;
    logic              tx_empty_irq_en;
    logic              tx_done_irq_en;
    logic              rx_irq_en;
    logic              idle_irq_en;
    logic              tx_enable_bit;
    logic              rx_enable;
    logic              rx_standby;
    logic              break_send;
    logic [1:0]        presc_sel;
    logic [3:0]        presc_cnt;
    logic [6:0]        rate_cnt;
    logic [3:0]        tx_rt;
    logic [10:0]       tx_shift;
    logic [3:0]        tx_left;
    logic [7:0]        tx_data;
    logic              pre_pend;
    logic              brk_act;
    logic              txd;
    logic              irq;
    logic [31:0]       prdata;
    logic              pready;
  } asrx_state_type;

  // bits that keep their value through reset
  typedef struct packed {
    logic       width9;
    logic       wake_adr;
    logic       rx_ninth_bit;
    logic       tx_ninth_bit;
    logic [2:0] rate_sel;
  } asrx_keep_type;

  asrx_state_type   s_r;
  asrx_state_type   s_nxt;
  asrx_keep_type    k_r;
  asrx_keep_type    k_nxt;
  asrx_apb_req_type req;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  function automatic logic [3:0] presc_max(input logic [1:0] sel);
    unique case (sel)
      2'b00:   presc_max = PRESC_MAX_D1;
      2'b01:   presc_max = PRESC_MAX_D3;
      2'b10:   presc_max = PRESC_MAX_D4;
      default: presc_max = PRESC_MAX_D13;
    endcase
  endfunction : presc_max

  function automatic logic [6:0] rate_max(input logic [2:0] sel);
    rate_max = 7'((8'h01 << sel) - 8'h01);
  endfunction : rate_max

  function automatic logic vote3(input logic [2:0] v);
    vote3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : vote3

  always_comb begin
    logic            presc_tick;
    logic            rt_tick;
    logic            tx_tick;
    logic            acc;
    logic            done;
    logic [4:0]      pos;
    logic            rxs;
    logic            vote;
    logic            disagree;
    logic [3:0]      nbits;
    logic [3:0]      flen;
    logic [7:0]      idle_lim;
    logic            active;
    logic            brk;
    logic [1:0]      vlow;
    asrx_status_type clr;
    presc_tick = 1'b0;
    rt_tick    = 1'b0;
    tx_tick    = 1'b0;
    acc        = req.psel & req.penable & ~s_r.pready;
    done       = req.psel & req.penable & s_r.pready;
    pos        = 5'h00;
    rxs        = rx_serial_in;
    vote       = 1'b0;
    disagree   = 1'b0;
    nbits      = k_r.width9 ? DATA_BITS9 : DATA_BITS8;
    flen       = k_r.width9 ? FRAME_LEN9 : FRAME_LEN8;
    idle_lim   = k_r.width9 ? IDLE_RT9 : IDLE_RT8;
    active     = 1'b0;
    brk        = 1'b0;
    vlow       = 2'h0;
    clr        = '0;
    s_nxt      = s_r;
    k_nxt      = k_r;

    // baud chain: prescaler, then power-of-two divider, gives the 16x sample tick
    presc_tick = (s_r.presc_cnt == presc_max(s_r.presc_sel));
    s_nxt.presc_cnt = presc_tick ? 4'h0 : s_r.presc_cnt + 4'h1;
    if (presc_tick) begin
      // rate select has no reset: the if keeps the counter known until software sets it
      rt_tick = (s_r.rate_cnt >= rate_max(k_r.rate_sel));
      if (rt_tick) begin
        s_nxt.rate_cnt = 7'h00;
      end else begin
        s_nxt.rate_cnt = s_r.rate_cnt + 7'h01;
      end
    end
    if (rt_tick) begin
      s_nxt.tx_rt = s_r.tx_rt + 4'h1;
    end
    tx_tick = rt_tick & (s_r.tx_rt == TX_RT_LAST);

    // apb slave: one wait state, read data registered with pready, write effects at the completing edge
    s_nxt.pready = acc;
    if (acc) begin
      unique case (req.paddr)
        ADDR_DATA:   s_nxt.prdata = {24'h000000, s_r.rx_data};
        ADDR_CTRL1:  s_nxt.prdata = {24'h000000, k_r.rx_ninth_bit, k_r.tx_ninth_bit, 1'b0,
                                     k_r.width9, k_r.wake_adr, 3'h0};
        ADDR_CTRL2:  s_nxt.prdata = {24'h000000, s_r.tx_empty_irq_en, s_r.tx_done_irq_en,
                                     s_r.rx_irq_en, s_r.idle_irq_en, s_r.tx_enable_bit,
                                     s_r.rx_enable, s_r.rx_standby, s_r.break_send};
        ADDR_STATUS: s_nxt.prdata = {24'h000000, s_r.flags, 1'b0};
        ADDR_BAUD:   s_nxt.prdata = {26'h0000000, s_r.presc_sel, 1'b0, k_r.rate_sel};
        default:     s_nxt.prdata = 32'h00000000;
      endcase
    end
    if (done && req.pwrite) begin
      unique case (req.paddr)
        ADDR_DATA: begin
          s_nxt.tx_data = req.pwdata[7:0];
          clr.tx_empty_flag = s_r.armed.tx_empty_flag;
          clr.tx_done_flag  = s_r.armed.tx_done_flag;
          s_nxt.armed.tx_empty_flag = 1'b0;
          s_nxt.armed.tx_done_flag  = 1'b0;
        end
        ADDR_CTRL1: begin
          k_nxt.tx_ninth_bit = req.pwdata[C1_TX_NINTH];
          k_nxt.width9       = req.pwdata[C1_WIDTH9];
          k_nxt.wake_adr     = req.pwdata[C1_WAKE_ADR];
        end
        ADDR_CTRL2: begin
          s_nxt.tx_empty_irq_en = req.pwdata[C2_TX_EMPTY_IE];
          s_nxt.tx_done_irq_en  = req.pwdata[C2_TX_DONE_IE];
          s_nxt.rx_irq_en       = req.pwdata[C2_RX_IE];
          s_nxt.idle_irq_en     = req.pwdata[C2_IDLE_IE];
          s_nxt.tx_enable_bit   = req.pwdata[C2_TX_EN];
          s_nxt.rx_enable       = req.pwdata[C2_RX_EN];
          s_nxt.rx_standby      = req.pwdata[C2_RX_STANDBY];
          s_nxt.break_send      = req.pwdata[C2_BREAK_SEND];
          if (req.pwdata[C2_TX_EN] && !s_r.tx_enable_bit) begin
            s_nxt.pre_pend = 1'b1;
          end
        end
        ADDR_BAUD: begin
          s_nxt.presc_sel = req.pwdata[BD_PRESC_LO +: 2];
          k_nxt.rate_sel  = req.pwdata[BD_RATE_LO +: 3];
        end
        default: begin
        end
      endcase
    end
    if (done && !req.pwrite) begin
      if (req.paddr == ADDR_STATUS) begin
        s_nxt.armed = s_r.flags;
      end else if (req.paddr == ADDR_DATA) begin
        clr.rx_full_flag       = s_r.armed.rx_full_flag;
        clr.idle_flag          = s_r.armed.idle_flag;
        clr.overrun_flag       = s_r.armed.overrun_flag;
        clr.noise_flag         = s_r.armed.noise_flag;
        clr.framing_error_flag = s_r.armed.framing_error_flag;
        s_nxt.armed = s_r.armed & {2'b11, 5'h00};
      end
    end
    // clears first so that a flag set in the same cycle survives
    s_nxt.flags = s_r.flags & ~clr;

    // receiver, one step per sample tick
    if (rt_tick && s_r.rx_enable) begin
      unique case (s_r.rx_state)
        RX_IDLE: begin
          if (rxs) begin
            s_nxt.hi_seen = 1'b1;
            if (s_r.idle_cnt != idle_lim) begin
              s_nxt.idle_cnt = s_r.idle_cnt + 8'h01;
            end
            if (s_r.idle_cnt + 8'h01 == idle_lim) begin
              if (s_r.rx_standby) begin
                if (!k_r.wake_adr) begin
                  s_nxt.rx_standby = 1'b0;
                end
              end else if (s_r.char_seen) begin
                s_nxt.flags.idle_flag = 1'b1;
                s_nxt.char_seen = 1'b0;
              end
            end
          end else begin
            s_nxt.idle_cnt = 8'h00;
            // a start edge needs a high level first; after a break this waits for a real one
            if (s_r.hi_seen) begin
              s_nxt.rx_state  = RX_BITS;
              s_nxt.rt_cnt    = RT_FIRST;
              s_nxt.bit_idx   = 4'h0;
              s_nxt.ver_low   = 2'h0;
              s_nxt.noise_acc = 1'b0;
              s_nxt.fe_hold   = 1'b0;
              // stale bits of the last character would hide an 8-bit break
              s_nxt.rx_shift  = 9'h000;
            end
          end
        end
        RX_BITS: begin
          pos = (s_r.rt_cnt == RT_WRAP) ? RT_FIRST : s_r.rt_cnt + 5'h01;
          s_nxt.rt_cnt = pos;
          if (pos == RT_FIRST) begin
            s_nxt.bit_idx = s_r.bit_idx + 4'h1;
            if (s_r.fe_hold) begin
              // artificial start: qualifiers read high, edge taken no sooner than expected
              s_nxt.rx_state = RX_IDLE;
              s_nxt.hi_seen  = 1'b1;
              s_nxt.fe_hold  = 1'b0;
            end
          end
          vlow = s_r.ver_low + {1'b0, ~rxs};
          if (s_r.bit_idx == 4'h0 &&
              (pos == RT_VER1 || pos == RT_VER2 || pos == RT_VER3)) begin
            s_nxt.ver_low = vlow;
            if (rxs) begin
              s_nxt.noise_acc = 1'b1;
            end
            if (pos == RT_VER3 && vlow < VER_MIN_LOW) begin
              s_nxt.rx_state = RX_IDLE;
            end
          end
          if (pos == RT_SMP1 || pos == RT_SMP2 || pos == RT_SMP3) begin
            s_nxt.smp = {rxs, s_r.smp[2:1]};
          end
          if (pos == RT_SMP3 && !s_r.fe_hold) begin
            vote     = vote3({rxs, s_r.smp[2:1]});
            disagree = !(rxs == s_r.smp[2] && rxs == s_r.smp[1]);
            if (disagree) begin
              s_nxt.noise_acc = 1'b1;
            end
            if (s_r.bit_idx == 4'h0) begin
              if (vote) begin
                s_nxt.rx_state = RX_IDLE;
              end
            end else if (s_r.bit_idx <= nbits) begin
              s_nxt.rx_shift = {vote, s_r.rx_shift[8:1]};
            end else begin
              // stop bit: the character's msb sits in shift bit 8 for both widths
              brk    = ~vote & (s_r.rx_shift == 9'h000);
              active = ~s_r.rx_standby | (k_r.wake_adr & s_r.rx_shift[8]);
              if (s_r.rx_standby && active) begin
                s_nxt.rx_standby = 1'b0;
              end
              if (active) begin
                s_nxt.char_seen = 1'b1;
                if (s_nxt.flags.rx_full_flag) begin
                  s_nxt.flags.overrun_flag = 1'b1;
                end else begin
                  s_nxt.flags.rx_full_flag       = 1'b1;
                  s_nxt.flags.noise_flag         = s_nxt.noise_acc;
                  s_nxt.flags.framing_error_flag = ~vote;
                  if (brk) begin
                    s_nxt.rx_data = BREAK_DATA;
                  end else begin
                    s_nxt.rx_data = k_r.width9 ? s_r.rx_shift[7:0] : s_r.rx_shift[8:1];
                  end
                  if (k_r.width9) begin
                    k_nxt.rx_ninth_bit = s_r.rx_shift[8];
                  end
                end
              end
              if (brk) begin
                s_nxt.rx_state = RX_IDLE;
                s_nxt.hi_seen  = 1'b0;
              end else if (!vote) begin
                s_nxt.fe_hold = 1'b1;
              end else begin
                s_nxt.rx_state = RX_IDLE;
                s_nxt.hi_seen  = 1'b1;
              end
            end
          end
        end
        default: begin
          s_nxt.rx_state = RX_IDLE;
        end
      endcase
    end
    if (!s_r.rx_enable) begin
      s_nxt.rx_state = RX_IDLE;
      s_nxt.hi_seen  = 1'b0;
      s_nxt.idle_cnt = 8'h00;
    end

    // transmitter: a bit lasts sixteen sample ticks, line holds high when nothing is queued
    if (tx_tick) begin
      if (s_r.tx_left != 4'h0) begin
        s_nxt.txd      = s_r.tx_shift[0];
        s_nxt.tx_shift = {1'b1, s_r.tx_shift[10:1]};
        s_nxt.tx_left  = s_r.tx_left - 4'h1;
      end else if (s_r.tx_enable_bit && s_r.pre_pend) begin
        s_nxt.txd      = 1'b1;
        s_nxt.tx_shift = 11'h7ff;
        s_nxt.tx_left  = flen - 4'h1;
        s_nxt.pre_pend = 1'b0;
      end else if (s_r.tx_enable_bit && s_r.break_send) begin
        s_nxt.txd      = 1'b0;
        s_nxt.tx_shift = 11'h000;
        s_nxt.tx_left  = flen - 4'h1;
        s_nxt.brk_act  = 1'b1;
      end else if (s_r.brk_act) begin
        s_nxt.txd     = 1'b1;
        s_nxt.brk_act = 1'b0;
      end else if (s_r.tx_enable_bit && !s_r.flags.tx_empty_flag) begin
        s_nxt.txd      = 1'b0;
        s_nxt.tx_shift = {1'b1, k_r.width9 ? k_r.tx_ninth_bit : 1'b1, s_r.tx_data, 1'b0};
        s_nxt.tx_shift = {1'b1, s_nxt.tx_shift[10:1]};
        s_nxt.tx_left  = flen - 4'h1;
        s_nxt.flags.tx_empty_flag = 1'b1;
      end else begin
        s_nxt.txd = 1'b1;
        if (s_r.flags.tx_empty_flag) begin
          s_nxt.flags.tx_done_flag = 1'b1;
        end
      end
      if (s_r.tx_left == 4'h0 && s_nxt.tx_left != 4'h0) begin
        s_nxt.flags.tx_done_flag = 1'b0;
      end
    end

    // receiver requests are also gated by the receiver enable
    s_nxt.irq = (s_nxt.tx_empty_irq_en & s_nxt.flags.tx_empty_flag) |
                (s_nxt.tx_done_irq_en & s_nxt.flags.tx_done_flag) |
                (s_nxt.rx_enable & s_nxt.rx_irq_en &
                 (s_nxt.flags.rx_full_flag | s_nxt.flags.overrun_flag)) |
                (s_nxt.rx_enable & s_nxt.idle_irq_en & s_nxt.flags.idle_flag);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.hi_seen <= 1'b1;
      s_r.flags.tx_empty_flag <= 1'b1;
      s_r.flags.tx_done_flag  <= 1'b1;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // width, wake method, ninth bits and rate select survive reset, so no reset term here
  always_ff @(posedge pclk) begin
    k_r <= k_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
    end
  end

  assign prdata        = s_r.prdata;
  assign pready        = s_r.pready;
  assign tx_serial_out = s_r.txd;
  assign irq           = s_r.irq;

endmodule : asrx_core
`default_nettype wire

/* File: logic/asrx_pkg.sv */
// constants, field layouts and carrier types for the serial receiver/transmitter core
package asrx_pkg;

  // register byte addresses on the apb side
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_CTRL2  = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_BAUD   = 8'h10;

  // serial_control_one fields
  localparam int C1_RX_NINTH = 7;
  localparam int C1_TX_NINTH = 6;
  localparam int C1_WIDTH9   = 4;
  localparam int C1_WAKE_ADR = 3;
  // serial_control_two fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE  = 6;
  localparam int C2_RX_IE       = 5;
  localparam int C2_IDLE_IE     = 4;
  localparam int C2_TX_EN       = 3;
  localparam int C2_RX_EN       = 2;
  localparam int C2_RX_STANDBY  = 1;
  localparam int C2_BREAK_SEND  = 0;
  // baud register fields
  localparam int BD_PRESC_LO = 4;
  localparam int BD_RATE_LO  = 0;

  // prescaler terminal counts for divide by 1, 3, 4 and 13
  localparam logic [3:0] PRESC_MAX_D1  = 4'h0;
  localparam logic [3:0] PRESC_MAX_D3  = 4'h2;
  localparam logic [3:0] PRESC_MAX_D4  = 4'h3;
  localparam logic [3:0] PRESC_MAX_D13 = 4'hc;

  // sample tick positions within one bit, position 1 is the expected bit start
  localparam logic [4:0] RT_FIRST = 5'h01;
  localparam logic [4:0] RT_VER1  = 5'h03;
  localparam logic [4:0] RT_VER2  = 5'h05;
  localparam logic [4:0] RT_VER3  = 5'h07;
  localparam logic [4:0] RT_SMP1  = 5'h08;
  localparam logic [4:0] RT_SMP2  = 5'h09;
  localparam logic [4:0] RT_SMP3  = 5'h0a;
  localparam logic [4:0] RT_WRAP  = 5'h10;
  localparam logic [1:0] VER_MIN_LOW = 2'h2;
  localparam logic [3:0] TX_RT_LAST  = 4'hf;

  // character geometry, in bits and in sample ticks
  localparam logic [3:0] FRAME_LEN8 = 4'ha;
  localparam logic [3:0] FRAME_LEN9 = 4'hb;
  localparam logic [3:0] DATA_BITS8 = 4'h8;
  localparam logic [3:0] DATA_BITS9 = 4'h9;
  localparam logic [7:0] IDLE_RT8   = 8'ha0;
  localparam logic [7:0] IDLE_RT9   = 8'hb0;
  localparam logic [7:0] BREAK_DATA = 8'h3b;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_BITS = 2'b01
  } asrx_rx_state_type;

  typedef struct packed {
    logic tx_empty_flag;
    logic tx_done_flag;
    logic rx_full_flag;
    logic idle_flag;
    logic overrun_flag;
    logic noise_flag;
    logic framing_error_flag;
  } asrx_status_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } asrx_apb_req_type;

endpackage : asrx_pkg

/* File: dv/asrx_core_sva.sv */
// pin-level assertions for the serial core
`timescale 1ns/1ps
`default_nettype none
module asrx_core_sva
  import asrx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_serial_in,
  input wire logic        tx_serial_out,
  input wire logic        irq
);
  logic       ctl_wr;
  logic       tx_en_r;
  logic       ie_r;
  logic [7:0] pre_cnt_r;
  assign ctl_wr = psel && penable && pready && pwrite && (paddr == ADDR_CTRL2);
  // preamble age in clocks; only meaningful at the fastest baud setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_en_r <= 1'b0;
      ie_r <= 1'b0;
      pre_cnt_r <= 8'h00;
    end else begin
      if (ctl_wr) begin
        tx_en_r <= pwdata[C2_TX_EN];
        ie_r <= |pwdata[7:4];
      end
      if (ctl_wr && pwdata[C2_TX_EN] && !tx_en_r) begin
        pre_cnt_r <= 8'h00;
      end else if (pre_cnt_r != 8'hff) begin
        pre_cnt_r <= pre_cnt_r + 8'h01;
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rdy_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_rdy_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  chk_rdy_cause: assert property (pready |-> psel && penable)
    else $error("pready without access");
  chk_no_slverr: assert property (pready |-> !pslverr)
    else $error("pslverr raised");
  chk_rd_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_tx_reset: assert property ($rose(presetn) |-> tx_serial_out)
    else $error("tx low after reset");
  chk_tx_bit_len: assert property ($changed(tx_serial_out) |=>
    $stable(tx_serial_out)[*8] ##1 $stable(tx_serial_out)[*7]) else $error("tx bit short");
  chk_tx_preamble: assert property (tx_en_r && pre_cnt_r < 8'h9e |-> tx_serial_out)
    else $error("preamble short");
  chk_irq_gated: assert property (!ie_r && !$past(ie_r) && !$past(ie_r, 2) |-> !irq)
    else $error("irq while disabled");
  cover property (pready && !pwrite && paddr == ADDR_DATA);
  cover property ($fell(tx_serial_out));
  cover property ($rose(irq));
endmodule : asrx_core_sva
bind asrx_core asrx_core_sva i_asrx_core_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_serial_in(rx_serial_in),
  .tx_serial_out(tx_serial_out), .irq(irq));
`default_nettype wire

/* File: dv/asrx_node.sv */
// remote serial node: drives the receive line and captures the transmit line
`timescale 1ns/1ps
`default_nettype none
module asrx_node (
  input  wire logic pclk,
  input  wire logic tx_serial_out,
  output var  logic rx_serial_in
);
  initial rx_serial_in = 1'b1;
  // gbit flips one mid-bit clock of that frame bit; -1 sends it clean
  task automatic send(input logic [8:0] d, input int nb, input logic stp, input int gbit);
    logic [10:0] f;
    f = 11'h7ff;
    f[0] = 1'b0;
    for (int i = 0; i < nb; i++) f[i + 1] = d[i];
    f[nb + 1] = stp;
    for (int i = 0; i <= nb + 1; i++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge pclk);
        rx_serial_in <= (i == gbit && c == 9) ? ~f[i] : f[i];
      end
    end
    @(posedge pclk);
    rx_serial_in <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask : send
  task automatic grab(input int nb, output logic [8:0] d, output logic ok, output int wt);
    wt = 0;
    d = 9'h000;
    while (tx_serial_out !== 1'b0 && wt < 4000) begin
      @(posedge pclk);
      wt++;
    end
    repeat (8) @(posedge pclk);
    ok = (tx_serial_out === 1'b0);
    for (int i = 0; i < nb; i++) begin
      repeat (16) @(posedge pclk);
      d[i] = tx_serial_out;
    end
    repeat (16) @(posedge pclk);
    ok = ok && (tx_serial_out === 1'b1);
    repeat (8) @(posedge pclk);
  endtask : grab
endmodule : asrx_node
`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  import asrx_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, rx_serial_in, tx_serial_out, irq, ok;
  logic [8:0]  rx9;
  logic [7:0]  q;
  int          wt;
  int          n_fail = 0;
  int          samples_checked = 0;
  always #10 pclk = ~pclk;
  asrx_core i_asrx_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_serial_in(rx_serial_in), .tx_serial_out(tx_serial_out), .irq(irq));
  asrx_node i_asrx_node (.pclk(pclk), .tx_serial_out(tx_serial_out), .rx_serial_in(rx_serial_in));
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, r);
    `CHK(r & m, e)
  endtask : rdc
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CTRL2, 8'hff, 8'h00);
    rdc(ADDR_STATUS, 8'hff, 8'hc0);
    rdc(8'h14, 8'hff, 8'h00);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CTRL1, 8'h00);
    wr(ADDR_CTRL2, 8'h04);
    i_asrx_node.send(9'h0a5, 8, 1'b1, 4);
    rdc(ADDR_STATUS, 8'h26, 8'h24);
    rdc(ADDR_DATA, 8'hff, 8'ha5);
    rdc(ADDR_STATUS, 8'h26, 8'h00);
    i_asrx_node.send(9'h000, 8, 1'b0, -1);
    rdc(ADDR_STATUS, 8'h22, 8'h22);
    rdc(ADDR_DATA, 8'hff, 8'h3b);
    i_asrx_node.send(9'h055, 8, 1'b0, -1);
    rdc(ADDR_STATUS, 8'h22, 8'h22);
    xfer(1'b0, ADDR_DATA, 8'h00, q);
    i_asrx_node.send(9'h031, 8, 1'b1, -1);
    rdc(ADDR_STATUS, 8'h22, 8'h20);
    rdc(ADDR_DATA, 8'hff, 8'h31);
    wr(ADDR_CTRL1, 8'h08);
    rdc(ADDR_CTRL1, 8'h18, 8'h08);
    wr(ADDR_CTRL2, 8'h06);
    i_asrx_node.send(9'h012, 8, 1'b1, -1);
    rdc(ADDR_STATUS, 8'h2e, 8'h00);
    rdc(ADDR_CTRL2, 8'h02, 8'h02);
    i_asrx_node.send(9'h093, 8, 1'b1, -1);
    rdc(ADDR_CTRL2, 8'h02, 8'h00);
    rdc(ADDR_STATUS, 8'h20, 8'h20);
    rdc(ADDR_DATA, 8'hff, 8'h93);
    wr(ADDR_CTRL1, 8'h00);
    fork
      i_asrx_node.send(9'h066, 8, 1'b1, -1);
      begin
        repeat (30) @(posedge pclk);
        wr(ADDR_CTRL2, 8'h06);
      end
    join
    repeat (80) @(posedge pclk);
    rdc(ADDR_CTRL2, 8'h02, 8'h02);
    rdc(ADDR_STATUS, 8'h20, 8'h00);
    repeat (100) @(posedge pclk);
    rdc(ADDR_CTRL2, 8'h02, 8'h00);
    wr(ADDR_CTRL2, 8'h0c);
    rdc(ADDR_STATUS, 8'hc0, 8'hc0);
    wr(ADDR_DATA, 8'h5a);
    i_asrx_node.grab(8, rx9, ok, wt);
    `CHK(ok, 1'b1)
    `CHK(rx9, 9'h05a)
    `CHK(wt > 140, 1'b1)
    wr(ADDR_CTRL1, 8'h50);
    rdc(ADDR_CTRL1, 8'h58, 8'h50);
    rdc(ADDR_STATUS, 8'h80, 8'h80);
    wr(ADDR_DATA, 8'h3c);
    i_asrx_node.grab(9, rx9, ok, wt);
    `CHK(rx9, 9'h13c)
    i_asrx_node.send(9'h1c3, 9, 1'b1, -1);
    rdc(ADDR_STATUS, 8'h20, 8'h20);
    rdc(ADDR_CTRL1, 8'h80, 8'h80);
    rdc(ADDR_DATA, 8'hff, 8'hc3);
    wr(ADDR_CTRL2, 8'h4c);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b1)
    wr(ADDR_CTRL2, 8'h0c);
    repeat (4) @(posedge pclk);
    `CHK(irq, 1'b0)
    wr(ADDR_CTRL2, 8'h0d);
    repeat (60) @(posedge pclk);
    `CHK(tx_serial_out, 1'b0)
    repeat (200) @(posedge pclk);
    `CHK(tx_serial_out, 1'b0)
    rdc(ADDR_STATUS, 8'h40, 8'h00);
    wr(ADDR_CTRL2, 8'h0c);
    repeat (400) @(posedge pclk);
    `CHK(tx_serial_out, 1'b1)
    rdc(ADDR_STATUS, 8'h40, 8'h40);
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
